// >>> rbt_consts.vh
`ifndef RBT_CONSTS_VH
`define RBT_CONSTS_VH
// ==========================================================
// register offsets
`define RBT_ADDR_TEMP       8'h8A
`define RBT_ADDR_VOUT_HI    8'h8B
`define RBT_ADDR_VOUT_LO    8'h8C
`define RBT_ADDR_FAULT      8'h8D
`define RBT_ADDR_REJECT     8'h8E
`define RBT_ADDR_CEIL_LO    8'h9C
// ==========================================================
// fields and reset values
`define RBT_CEIL_LO_RST     8'hFF
`define RBT_FLT_HOT_BIT     6
`define RBT_FLT_OCW_BIT     5
`define RBT_TEMP_OFS_C      8'h28
`define RBT_VOUT_LSB_UV     5000
`define RBT_CEIL_BASE_UV    24'h03BD08
`define RBT_CEIL_STEP_UV    24'h001388
`define RBT_ZERO24          24'h000000
`define RBT_ZERO9           9'h000
`define RBT_ZERO8           8'h00
`define RBT_ZERO2           2'h0
`define RBT_ZERO6           6'h00
`define RBT_ZERO1           1'h0
`endif

// >>> rbt_ceiling_calc.v
`timescale 1ns/10ps
// ==========================================================
// ceiling code to voltage in microvolts
module rbt_ceiling_calc (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // code in
  input  wire [8:0]  ceil_code,
  // voltage out, microvolts
  output reg  [23:0] ceil_uv_q
);
`include "rbt_consts.vh"

  wire [23:0] step_uv;
  wire [23:0] calc_uv;
  reg  [23:0] ceil_uv_d;

  assign step_uv = ceil_code * `RBT_CEIL_STEP_UV;
  assign calc_uv = step_uv + `RBT_CEIL_BASE_UV;

  always @* begin
    if (ceil_code == `RBT_ZERO9) begin
      ceil_uv_d = `RBT_ZERO24;
    end else begin
      ceil_uv_d = calc_uv;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ceil_uv_q <= `RBT_ZERO24;
    end else begin
      ceil_uv_q <= ceil_uv_d;
    end
  end
endmodule // rbt_ceiling_calc

// >>> rbt_regs.v
`timescale 1ns/10ps
// Overview of operation
// - temperature reading is an 8-bit read-only code, degrees equal code minus 40.
// - output voltage reading is 10 bits, high two in 0x8B, low eight in 0x8C, 5mV.
// - bit 6 of fault flags sets on regulator-hot warning, else stays zero.
// - bit 5 of fault flags sets on overcurrent warning, else stays zero.
// - writing one clears a warning bit; writing zero leaves it.
// - bits 4..0 show over-temp, undervoltage, overvoltage, overcurrent, softstart; bit 7 reserved.
// - reject status mirrors the voltage link status register.
// - bits 5, 4, 3 flag early command, framing error, CRC error.
// - bits 2, 1, 0 flag undefined register, undefined payload, unsupported; 7..6 reserved.
// - ceiling code is 9 bits: top bit external, low eight from 0x9C.
// - nonzero ceiling gives 0.245V plus 5mV per count.
// - ceiling code zero means zero volts.
// - ceiling low byte resets to 0xFF.
module rbt_regs (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // host register port
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata_q,
  // telemetry from rail (asynchronous)
  input  wire [7:0]  temperature_reading,
  input  wire [9:0]  output_voltage_reading,
  // fault events (asynchronous)
  input  wire        regulator_hot_warning,
  input  wire        overcurrent_warning,
  input  wire        overtemp_trip,
  input  wire        undervoltage_trip,
  input  wire        overvoltage_trip,
  input  wire        overcurrent_trip,
  input  wire        softstart_overcurrent_trip,
  // voltage link reject status (asynchronous)
  input  wire [5:0]  link_reject_status,
  // ceiling top bit from neighbouring register
  input  wire        ceiling_msb,
  // ceiling outputs
  output reg  [8:0]  fixed_mode_voltage_ceiling_q,
  output wire [23:0] ceiling_uv_q
);
`include "rbt_consts.vh"

  // ==========================================================
  // input synchronisers
  localparam SW = 32;
  wire [SW-1:0] async_in;
  reg  [SW-1:0] meta_q;
  reg  [SW-1:0] sync_q;

  assign async_in = {temperature_reading, output_voltage_reading,
                     regulator_hot_warning, overcurrent_warning,
                     overtemp_trip, undervoltage_trip, overvoltage_trip,
                     overcurrent_trip, softstart_overcurrent_trip,
                     link_reject_status, ceiling_msb};

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi = gi + 1) begin : g_sync
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  wire [7:0] temp_s;
  wire [9:0] vout_s;
  wire       hot_s;
  wire       ocw_s;
  wire [4:0] trips_s;
  wire [5:0] reject_s;
  wire       ceil_msb_s;

  assign temp_s     = sync_q[31:24];
  assign vout_s     = sync_q[23:14];
  assign hot_s      = sync_q[13];
  assign ocw_s      = sync_q[12];
  assign trips_s    = sync_q[11:7];
  assign reject_s   = sync_q[6:1];
  assign ceil_msb_s = sync_q[0];

  // ==========================================================
  // address decode, one select per register
  wire       sel_temp;
  wire       sel_vout_hi;
  wire       sel_vout_lo;
  wire       sel_fault;
  wire       sel_reject;
  wire       sel_ceil_lo;
  wire       wr_ceil;
  wire       wr_fault;
  wire       rd_hi;
  wire       rd_lo;

  assign sel_temp    = (reg_addr == `RBT_ADDR_TEMP);
  assign sel_vout_hi = (reg_addr == `RBT_ADDR_VOUT_HI);
  assign sel_vout_lo = (reg_addr == `RBT_ADDR_VOUT_LO);
  assign sel_fault   = (reg_addr == `RBT_ADDR_FAULT);
  assign sel_reject  = (reg_addr == `RBT_ADDR_REJECT);
  assign sel_ceil_lo = (reg_addr == `RBT_ADDR_CEIL_LO);
  assign wr_ceil     = reg_wr && sel_ceil_lo;
  assign wr_fault    = reg_wr && sel_fault;
  assign rd_hi       = reg_rd && sel_vout_hi;
  assign rd_lo       = reg_rd && sel_vout_lo;

  // ==========================================================
  // ceiling low byte, the only fully writable register here
  reg  [7:0] ceil_lo_q;
  reg  [7:0] ceil_lo_d;

  always @* begin
    ceil_lo_d = ceil_lo_q;
    if (wr_ceil) begin
      ceil_lo_d = reg_wdata;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ceil_lo_q <= `RBT_CEIL_LO_RST;
    end else begin
      ceil_lo_q <= ceil_lo_d;
    end
  end

  // ==========================================================
  // ceiling code, top bit from the neighbouring register
  reg  [8:0] ceil_code_d;

  always @* begin
    ceil_code_d = {ceil_msb_s, ceil_lo_q};
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fixed_mode_voltage_ceiling_q <= `RBT_ZERO9;
    end else begin
      fixed_mode_voltage_ceiling_q <= ceil_code_d;
    end
  end

  // microvolt view of the ceiling code
  rbt_ceiling_calc rbt_ceiling_calc_i (
    .clk       (clk),
    .reset_n   (reset_n),
    .ceil_code (fixed_mode_voltage_ceiling_q),
    .ceil_uv_q (ceiling_uv_q)
  );

  // ==========================================================
  // sticky warning flags
  reg        hot_q;
  reg        hot_d;
  reg        ocw_q;
  reg        ocw_d;
  wire       clr_hot;
  wire       clr_ocw;

  assign clr_hot = wr_fault && reg_wdata[`RBT_FLT_HOT_BIT];
  assign clr_ocw = wr_fault && reg_wdata[`RBT_FLT_OCW_BIT];

  always @* begin
    hot_d = hot_q;
    ocw_d = ocw_q;
    if (clr_hot) begin
      hot_d = 1'b0;
    end
    if (clr_ocw) begin
      ocw_d = 1'b0;
    end
    // set applied last so an event in the clear cycle is not lost
    if (hot_s) begin
      hot_d = 1'b1;
    end
    if (ocw_s) begin
      ocw_d = 1'b1;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hot_q <= 1'b0;
      ocw_q <= 1'b0;
    end else begin
      hot_q <= hot_d;
      ocw_q <= ocw_d;
    end
  end

  // ==========================================================
  // low voltage byte capture on high read
  reg  [7:0] vout_lo_hold_q;
  reg  [7:0] vout_lo_hold_d;
  reg        hold_valid_q;
  reg        hold_valid_d;

  always @* begin
    vout_lo_hold_d = vout_lo_hold_q;
    hold_valid_d   = hold_valid_q;
    if (rd_hi) begin
      vout_lo_hold_d = vout_s[7:0];
      hold_valid_d   = 1'b1;
    end else if (rd_lo) begin
      hold_valid_d   = 1'b0;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vout_lo_hold_q <= `RBT_ZERO8;
      hold_valid_q   <= 1'b0;
    end else begin
      vout_lo_hold_q <= vout_lo_hold_d;
      hold_valid_q   <= hold_valid_d;
    end
  end

  // ==========================================================
  // register read views
  wire [7:0] temp_field;
  wire [7:0] vout_hi_field;
  reg  [7:0] vout_lo_field;
  wire [7:0] fault_field;
  wire [7:0] reject_field;

  assign temp_field    = temp_s;
  assign vout_hi_field = {`RBT_ZERO6, vout_s[9:8]};
  assign fault_field   = {`RBT_ZERO1, hot_q, ocw_q, trips_s};
  assign reject_field  = {`RBT_ZERO2, reject_s};

  // held byte only while a high read is pending
  always @* begin
    if (hold_valid_q) begin
      vout_lo_field = vout_lo_hold_q;
    end else begin
      vout_lo_field = vout_s[7:0];
    end
  end

  // ==========================================================
  // read data
  reg  [7:0] rdata_d;
  reg  [7:0] reg_rdata_d;

  always @* begin
    rdata_d = `RBT_ZERO8;
    case (reg_addr)
      `RBT_ADDR_TEMP: begin
        rdata_d = temp_field;
      end
      `RBT_ADDR_VOUT_HI: begin
        rdata_d = vout_hi_field;
      end
      `RBT_ADDR_VOUT_LO: begin
        rdata_d = vout_lo_field;
      end
      `RBT_ADDR_FAULT: begin
        rdata_d = fault_field;
      end
      `RBT_ADDR_REJECT: begin
        rdata_d = reject_field;
      end
      `RBT_ADDR_CEIL_LO: begin
        rdata_d = ceil_lo_q;
      end
      default: begin
        rdata_d = `RBT_ZERO8;
      end
    endcase
  end

  // read data updates only on a read; only 0x9C and the fault clear bits take a write
  always @* begin
    reg_rdata_d = reg_rdata_q;
    if (reg_rd) begin
      reg_rdata_d = rdata_d;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= `RBT_ZERO8;
    end else begin
      reg_rdata_q <= reg_rdata_d;
    end
  end
endmodule // rbt_regs

// >>> rbt_regs_monitor.sv
`timescale 1ns/10ps
// ======================================================
// checks on the register port and ceiling outputs
module rbt_regs_monitor (
  input wire        clk, reset_n, reg_wr, reg_rd, ceiling_msb,
  input wire [7:0]  reg_addr, reg_wdata, reg_rdata_q, temperature_reading,
  input wire [9:0]  output_voltage_reading,
  input wire [5:0]  link_reject_status,
  input wire [8:0]  fixed_mode_voltage_ceiling_q,
  input wire [23:0] ceiling_uv_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd(a); reg_rd && reg_addr == a; endsequence
  sequence s_vs; $stable(output_voltage_reading)[*3]; endsequence
  property p_tmp; $stable(temperature_reading)[*3] ##0 s_rd(8'h8A)
    |=> reg_rdata_q == $past(temperature_reading); endproperty
  a_tmp: assert property (p_tmp) else $error("temperature read wrong");
  property p_vhi; s_vs ##0 s_rd(8'h8B)
    |=> reg_rdata_q == {6'h00, $past(output_voltage_reading[9:8])}; endproperty
  a_vhi: assert property (p_vhi) else $error("voltage high read wrong");
  property p_pair; s_vs ##0 s_rd(8'h8B) ##1 s_rd(8'h8C)
    |=> reg_rdata_q == $past(output_voltage_reading[7:0], 2); endproperty
  a_pair: assert property (p_pair) else $error("voltage pair incoherent");
  property p_rej; $stable(link_reject_status)[*3] ##0 s_rd(8'h8E)
    |=> reg_rdata_q == {2'h0, $past(link_reject_status)}; endproperty
  a_rej: assert property (p_rej) else $error("reject status wrong");
  property p_low; reg_wr && reg_addr == 8'h9C ##1 (!reg_wr)[*5]
    |-> fixed_mode_voltage_ceiling_q[7:0] == $past(reg_wdata, 5); endproperty
  a_low: assert property (p_low) else $error("ceiling low byte wrong");
  property p_msb; $stable(ceiling_msb)[*4] |-> fixed_mode_voltage_ceiling_q[8] == ceiling_msb;
  endproperty
  a_msb: assert property (p_msb) else $error("ceiling top bit wrong");
  property p_uv; 1 |=> ceiling_uv_q == ($past(fixed_mode_voltage_ceiling_q) == 9'h000 ? 24'h0
    : 24'h3BD08 + 24'h1388 * $past(fixed_mode_voltage_ceiling_q)); endproperty
  a_uv: assert property (p_uv) else $error("ceiling voltage wrong");
  property p_hold; !reg_rd |=> $stable(reg_rdata_q); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unm; s_rd(8'h90) |=> reg_rdata_q == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule // rbt_regs_monitor

// >>> rbt_regs_bench.sv
`timescale 1ns/10ps
`define CHK(e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %0t exp %h got %h", $time, e, g); end end
// ======================================================
// bench
module rbt_regs_bench;
  reg        clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, hot = 0, ocw = 0, msb = 0, rd_d = 0;
  reg [7:0]  addr = 0, wd = 0, tmp = 0, ex, w;
  reg [9:0]  v = 0, vo;
  reg [8:0]  c9;
  reg [5:0]  rej = 0;
  reg [4:0]  tr = 0;
  wire [7:0] rdq;
  wire [8:0] code;
  wire [23:0] uv;
  int        errors = 0, total_checks = 0, i;
  logic [7:0] q[$];
  always #2 clk = ~clk;
  rbt_regs rbt_regs_i (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(addr), .reg_wdata(wd), .reg_rdata_q(rdq), .temperature_reading(tmp),
    .output_voltage_reading(v), .regulator_hot_warning(hot), .overcurrent_warning(ocw),
    .overtemp_trip(tr[4]), .undervoltage_trip(tr[3]), .overvoltage_trip(tr[2]),
    .overcurrent_trip(tr[1]), .softstart_overcurrent_trip(tr[0]), .link_reject_status(rej),
    .ceiling_msb(msb), .fixed_mode_voltage_ceiling_q(code), .ceiling_uv_q(uv));
  // ======================================================
  // read result watcher
  always @(posedge clk) begin
    if (rd_d) begin
      ex = q.pop_front();
      `CHK(ex, rdq)
    end
    rd_d <= reg_rd;
  end
  task rd(input [7:0] a, e); q.push_back(e); reg_rd <= 1; reg_wr <= 0; addr <= a;
    @(posedge clk); endtask
  task wr(input [7:0] a, d); reg_wr <= 1; reg_rd <= 0; addr <= a; wd <= d; @(posedge clk); endtask
  task idle(input int n); reg_rd <= 0; reg_wr <= 0; repeat (n) @(posedge clk); endtask
  task give_verdict;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ======================================================
  // stimulus
  initial begin
    i = $urandom(32'h4B2EFCA4);
    repeat (4) @(posedge clk);
    reset_n <= 1;
    idle(4);
    rd(8'h9C, 8'hFF);
    idle(1);
    `CHK(9'h0FF, code)
    `CHK(24'h3BD08 + 24'h1388 * 24'hFF, uv)
    repeat (4) begin
      tmp <= $urandom; v <= $urandom; rej <= $urandom; tr <= $urandom;
      idle(3);
      rd(8'h8A, tmp);
      rd(8'h8B, {6'h00, v[9:8]});
      rd(8'h8C, v[7:0]);
      vo = v; v <= $urandom;
      rd(8'h8B, {6'h00, vo[9:8]});
      idle(3);
      rd(8'h8C, vo[7:0]);
      rd(8'h8C, v[7:0]);
      rd(8'h8D, {3'h0, tr});
      rd(8'h8E, {2'h0, rej});
      wr(8'h8A, 8'h5A); wr(8'h8E, 8'h5A); wr(8'h8D, 8'h9F);
      rd(8'h8A, tmp); rd(8'h8E, {2'h0, rej}); rd(8'h8D, {3'h0, tr}); rd(8'h90, 8'h00);
    end
    for (i = 0; i < 2; i++) begin
      hot <= !i; ocw <= i; idle(1); hot <= 0; ocw <= 0; idle(3);
      w = i ? 8'h20 : 8'h40;
      rd(8'h8D, w | tr); wr(8'h8D, ~w & 8'h60);
      rd(8'h8D, w | tr); wr(8'h8D, w);
      rd(8'h8D, {3'h0, tr});
    end
    for (i = 0; i < 2; i++) begin
      w = i ? 8'h00 : $urandom; msb <= !i; c9 = {~i[0], w};
      wr(8'h9C, w); idle(6); rd(8'h9C, w); idle(1);
      `CHK(c9, code)
      `CHK(c9 ? 24'h3BD08 + 24'h1388 * c9 : 24'h0, uv)
    end
    idle(2);
    give_verdict;
  end
endmodule // rbt_regs_bench
bind rbt_regs rbt_regs_monitor rbt_regs_monitor_i (.*);
